// ==== rtl/laser_enable_interlock_sequencer.sv ====
`default_nettype none
// How it works
// - keyed unit stays disabled after power-up, fault or interlock until key toggled.
// - over-temperature latch survives key toggles; only power cycling clears it.
// - remote key reclose powers RF driver, waits five seconds, then enables lasing.
// - open remote key loop forces RF driver off regardless of other inputs.
// - keyed unit: ready and power indicator go active once enabled with RF power on.
// - ready and power indicator inactive whenever the unit is locked out.
// - keyless unit lights indicator at power-up, RF power five seconds later.
// - keyless fault cleared by 30 s power absence or remote key toggle; the code clears it on any nrst reset, with no 30 s timing.
// - RF power and lasing only while interlock closed; opening removes both.
// - after interlock reclose, stay disabled until a key toggle restarts wait.
// - interlock reads closed when pulled to ground, open when floating.
// - remote key input is debounced before its edges are used.
// - voltage, temperature or circuit failures latch and report a fault.
module laser_enable_interlock_sequencer
    import laser_seq_pkg::*;
#(
    parameter int unsigned WAIT_CYC = ENABLE_WAIT_CYC,
    parameter int unsigned DEBOUNCE = DEBOUNCE_CYC
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic keyless_variant,
    input wire laser_seq_pkg::contacts_s contacts,
    output laser_seq_pkg::drive_s drive
);
    import laser_seq_pkg::*;

    typedef enum logic [3:0] {
        ST_LOCKED = 4'h1,
        ST_ARMED  = 4'h2,
        ST_WAIT   = 4'h4,
        ST_LASE   = 4'h8
    } seq_e;

    // ****************************************
    // input conditioning
    // ****************************************
    logic [6:0] s1_reg, s2_reg;
    logic kl_s1_reg, kl_s2_reg;
    logic key_db, front_db;
    contact_debounce #(.COUNT(DEBOUNCE)) u_rkey (
        .sys_clk(sys_clk), .nrst(nrst), .raw(contacts.remote_key_closed), .clean(key_db));
    contact_debounce #(.COUNT(DEBOUNCE)) u_fkey (
        .sys_clk(sys_clk), .nrst(nrst), .raw(contacts.front_key_closed), .clean(front_db));

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= 7'h0;
            s2_reg <= 7'h0;
            kl_s1_reg <= 1'b0;
            kl_s2_reg <= 1'b0;
        end else begin
            s1_reg <= contacts;
            s2_reg <= s1_reg;
            kl_s1_reg <= keyless_variant;
            kl_s2_reg <= kl_s1_reg;
        end
    end

    contacts_s sc;
    assign sc = s2_reg;
    logic ilk_closed, fault_now, key_loop;
    assign ilk_closed = !sc.interlock_n;
    assign fault_now = sc.under_voltage | sc.over_voltage | sc.over_temp | sc.circuit_fail;
    // keyless units bypass the front key; remote loop is in series with it otherwise
    assign key_loop = key_db & (kl_s2_reg | front_db);

    // ****************************************
    // sequencer
    // ****************************************
    seq_e st_reg, st_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic key_prev_reg, key_prev_next, opened_reg, opened_next;
    logic fault_reg, fault_next, ot_reg, ot_next, boot_reg, boot_next;
    logic [CNT_W-1:0] settle_reg, settle_next;
    drive_s drv_reg, drv_next;
    logic toggled;

    // a toggle is a close after an observed open
    assign toggled = key_loop & !key_prev_reg & opened_reg;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        key_prev_next = key_loop;
        opened_next = opened_reg | !key_loop;
        boot_next = boot_reg;
        settle_next = settle_reg;
        fault_next = fault_reg | fault_now;
        ot_next = ot_reg | sc.over_temp;
        if (toggled && !sc.over_temp) begin
            // a fault still present at the toggle stays latched
            fault_next = ot_reg | fault_now;
            opened_next = 1'b0;
        end
        // debouncers leave reset reading open; ignore that false open until they settle
        if (boot_reg) begin
            settle_next = settle_reg + 1'b1;
            opened_next = 1'b0;
            if (settle_reg >= CNT_W'(DEBOUNCE + SYNC_SETTLE_CYC)) begin
                boot_next = 1'b0;
            end
        end
        case (st_reg)
            ST_LOCKED: begin
                cnt_next = '0;
                if (boot_reg && !boot_next && kl_s2_reg) begin
                    st_next = ST_ARMED;
                end else if (toggled && !ot_reg && ilk_closed) begin
                    st_next = ST_WAIT;
                end
            end
            ST_ARMED: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= CNT_W'(WAIT_CYC - 1)) begin
                    st_next = ST_WAIT;
                    cnt_next = '0;
                end
            end
            ST_WAIT: begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= CNT_W'(WAIT_CYC - 1)) begin
                    st_next = ST_LASE;
                end
            end
            ST_LASE: cnt_next = '0;
            default: st_next = ST_LOCKED;
        endcase
        if (!ilk_closed || !key_loop || fault_next) begin
            st_next = ST_LOCKED;
            cnt_next = '0;
        end
        drv_next.rf_power_on = (st_next == ST_WAIT) || (st_next == ST_LASE);
        drv_next.lase_enable = (st_next == ST_LASE);
        drv_next.power_on_indicator = st_next != ST_LOCKED;
        drv_next.ready_out = st_next != ST_LOCKED;
        drv_next.fault_shutdown = fault_next;
        drv_next.over_temp_latched = ot_next;
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_LOCKED;
            cnt_reg <= '0;
            key_prev_reg <= 1'b0;
            opened_reg <= 1'b0;
            fault_reg <= 1'b0;
            ot_reg <= 1'b0;
            boot_reg <= 1'b1;
            settle_reg <= '0;
            drv_reg <= '0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            key_prev_reg <= key_prev_next;
            opened_reg <= opened_next;
            fault_reg <= fault_next;
            ot_reg <= ot_next;
            boot_reg <= boot_next;
            settle_reg <= settle_next;
            drv_reg <= drv_next;
        end
    end

    assign drive = drv_reg;

    // ****************************************
    // checks
    // ****************************************
    property p_key_open;
        @(posedge sys_clk) disable iff (!nrst) !key_loop |=> !drive.rf_power_on;
    endproperty
    a_key_open: assert property (p_key_open) else $error("rf on with key open");

    property p_ilk_open;
        @(posedge sys_clk) disable iff (!nrst) !ilk_closed |=> !drive.lase_enable && !drive.rf_power_on;
    endproperty
    a_ilk_open: assert property (p_ilk_open) else $error("on with interlock open");

    property p_ot_hold;
        @(posedge sys_clk) disable iff (!nrst) ot_reg |=> ot_reg && drive.fault_shutdown;
    endproperty
    a_ot_hold: assert property (p_ot_hold) else $error("over temp cleared");

    property p_ready;
        @(posedge sys_clk) disable iff (!nrst) !drive.power_on_indicator |-> !drive.lase_enable;
    endproperty
    a_ready: assert property (p_ready) else $error("lase without ready");

    property p_ready_rf;
        @(posedge sys_clk) disable iff (!nrst) drive.rf_power_on |-> drive.ready_out;
    endproperty
    a_ready_rf: assert property (p_ready_rf) else $error("rf without ready");

    property p_fault;
        @(posedge sys_clk) disable iff (!nrst) fault_now |=> drive.fault_shutdown && !drive.rf_power_on;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not latched");

    property p_lase_entry;
        @(posedge sys_clk) disable iff (!nrst)
            $rose(drive.lase_enable) |-> $past(st_reg) == ST_WAIT && $past(cnt_reg) >= CNT_W'(WAIT_CYC - 1);
    endproperty
    a_lase_entry: assert property (p_lase_entry) else $error("lase before wait");

    property p_cnt_clear;
        @(posedge sys_clk) disable iff (!nrst) st_reg == ST_LOCKED |-> cnt_reg == '0;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("timer not restarted");

    property p_locked_stay;
        @(posedge sys_clk) disable iff (!nrst)
            st_reg == ST_LOCKED && !toggled && !boot_reg |=> st_reg == ST_LOCKED;
    endproperty
    a_locked_stay: assert property (p_locked_stay) else $error("left lock without toggle");

    property p_boot_hold;
        @(posedge sys_clk) disable iff (!nrst)
            boot_reg |-> st_reg == ST_LOCKED && !drive.rf_power_on;
    endproperty
    a_boot_hold: assert property (p_boot_hold) else $error("left lock while settling");
endmodule
`default_nettype wire

// ==== rtl/laser_seq_pkg.sv ====
`default_nettype none
package laser_seq_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned ENABLE_WAIT_S = 5;
    localparam int unsigned ENABLE_WAIT_CYC = ENABLE_WAIT_S * CLK_HZ;
    localparam int unsigned POWER_OFF_S = 30;
    localparam longint unsigned POWER_OFF_CYC = longint'(POWER_OFF_S) * longint'(CLK_HZ);
    localparam int unsigned DEBOUNCE_NS = 10_000_000;
    localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_NS + 4) / 5;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned SYNC_SETTLE_CYC = 3;

    // raw contact and fault inputs, sampled as a group
    typedef struct packed {
        logic front_key_closed;
        logic remote_key_closed;
        logic interlock_n;
        logic under_voltage;
        logic over_voltage;
        logic over_temp;
        logic circuit_fail;
    } contacts_s;

    // driven outputs, all registered
    typedef struct packed {
        logic rf_power_on;
        logic lase_enable;
        logic power_on_indicator;
        logic ready_out;
        logic fault_shutdown;
        logic over_temp_latched;
    } drive_s;
endpackage
`default_nettype wire

// ==== rtl/contact_debounce.sv ====
`default_nettype none
module contact_debounce #(
    parameter int unsigned COUNT = 2
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic raw,
    output logic clean
);
    logic sync1_reg, sync2_reg, clean_reg, clean_next;
    logic [31:0] cnt_reg, cnt_next;

    // ****************************************
    // synchroniser and stability counter
    // ****************************************
    always_comb begin
        clean_next = clean_reg;
        cnt_next = 32'h0;
        if (sync2_reg != clean_reg) begin
            if (cnt_reg >= COUNT - 1) begin
                clean_next = sync2_reg;
            end else begin
                cnt_next = cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            clean_reg <= 1'b0;
            cnt_reg <= 32'h0;
        end else begin
            sync1_reg <= raw;
            sync2_reg <= sync1_reg;
            clean_reg <= clean_next;
            cnt_reg <= cnt_next;
        end
    end

    assign clean = clean_reg;
endmodule
`default_nettype wire

// ==== tb/operator_panel.sv ====
`default_nettype none
module operator_panel
    import laser_seq_pkg::*;
#(
    parameter int unsigned DEB = 2
) (
    input wire logic sys_clk,
    output laser_seq_pkg::contacts_s contacts
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // contact levels
    // ****************
    initial begin
        contacts = '0;
        contacts.front_key_closed = 1'b1;
        contacts.remote_key_closed = 1'b1;
    end

    task automatic set_lock(input logic closed);
        @(posedge sys_clk) contacts.interlock_n <= ~closed;
    endtask

    task automatic set_fault(input logic [3:0] f);
        @(posedge sys_clk) contacts[3:0] <= f;
    endtask

    task automatic set_key(input logic closed);
        @(posedge sys_clk) contacts.remote_key_closed <= closed;
    endtask

    task automatic set_front(input logic closed);
        @(posedge sys_clk) contacts.front_key_closed <= closed;
    endtask

    // open long enough to pass the debounce, then close
    task automatic toggle_key();
        set_key(1'b0);
        repeat (DEB + 8) @(posedge sys_clk);
        set_key(1'b1);
    endtask
endmodule
`default_nettype wire

// ==== tb/laser_enable_interlock_sequencer_test.sv ====
`default_nettype none
module laser_enable_interlock_sequencer_test;
    import laser_seq_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned W = 20;
    localparam int unsigned DEB = 2;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic keyless_variant = 1'b0;
    contacts_s contacts;
    drive_s drive;
    logic [5:0] dv;
    int error_cnt = 0;
    int compares = 0;
    assign dv = drive;

    laser_enable_interlock_sequencer #(.WAIT_CYC(W), .DEBOUNCE(DEB))
    laser_enable_interlock_sequencer_inst (.sys_clk(sys_clk), .nrst(nrst),
        .keyless_variant(keyless_variant), .contacts(contacts), .drive(drive));
    operator_panel #(.DEB(DEB)) operator_panel_inst (.sys_clk(sys_clk), .contacts(contacts));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ****************
    // helpers
    // ****************
    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic seen, input logic exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %b seen %b", name, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wait_bit(input int b, input logic v);
        int n = 0;
        while (dv[b] !== v && n < 200) begin
            cyc(1);
            n++;
        end
        if (dv[b] !== v) begin
            error_cnt++;
            final_report();
        end
    endtask

    task automatic expect_at(input int b);
        cyc(W - 1);
        chk("delayed output early", dv[b], 1'b0);
        cyc(1);
        chk("delayed output on time", dv[b], 1'b1);
    endtask

    task automatic rst(input logic kl);
        @(posedge sys_clk);
        nrst <= 1'b0;
        keyless_variant <= kl;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_enable();
        operator_panel_inst.toggle_key();
        wait_bit(2, 1'b1);
        chk("rf_power_on", drive.rf_power_on, 1'b1);
        chk("power_on_indicator", drive.power_on_indicator, 1'b1);
        chk("lase_enable", drive.lase_enable, 1'b0);
        expect_at(4);
    endtask

    task automatic t_key_open();
        operator_panel_inst.set_key(1'b0);
        wait_bit(5, 1'b0);
        chk("ready_out", drive.ready_out, 1'b0);
        chk("lase_enable", drive.lase_enable, 1'b0);
        operator_panel_inst.set_key(1'b1);
        wait_bit(2, 1'b1);
        expect_at(4);
    endtask

    task automatic t_interlock();
        operator_panel_inst.set_lock(1'b0);
        wait_bit(5, 1'b0);
        chk("lase_enable", drive.lase_enable, 1'b0);
        chk("power_on_indicator", drive.power_on_indicator, 1'b0);
        operator_panel_inst.set_lock(1'b1);
        cyc(30);
        chk("rf_power_on", drive.rf_power_on, 1'b0);
        t_enable();
    endtask

    // front key open then closed acts as a keyswitch toggle on a keyed unit
    task automatic t_front_key();
        operator_panel_inst.set_front(1'b0);
        wait_bit(5, 1'b0);
        chk("ready_out", drive.ready_out, 1'b0);
        repeat (DEB + 8) @(posedge sys_clk);
        operator_panel_inst.set_front(1'b1);
        wait_bit(2, 1'b1);
        chk("rf_power_on", drive.rf_power_on, 1'b1);
        expect_at(4);
    endtask

    task automatic t_over_temp();
        operator_panel_inst.set_fault(4'h2);
        wait_bit(0, 1'b1);
        chk("fault_shutdown", drive.fault_shutdown, 1'b1);
        chk("ready_out", drive.ready_out, 1'b0);
        operator_panel_inst.set_fault(4'h0);
        operator_panel_inst.toggle_key();
        cyc(30);
        chk("rf_power_on", drive.rf_power_on, 1'b0);
        chk("over_temp_latched", drive.over_temp_latched, 1'b1);
        rst(1'b0);
        cyc(2);
        chk("over_temp_latched", drive.over_temp_latched, 1'b0);
        t_enable();
    endtask

    task automatic t_volt_faults();
        logic [3:0] codes [3] = '{4'h8, 4'h4, 4'h1};
        foreach (codes[i]) begin
            operator_panel_inst.set_fault(codes[i]);
            wait_bit(1, 1'b1);
            chk("rf_power_on", drive.rf_power_on, 1'b0);
            operator_panel_inst.set_fault(4'h0);
            t_enable();
            chk("fault_shutdown", drive.fault_shutdown, 1'b0);
        end
    endtask

    task automatic t_keyless();
        rst(1'b1);
        wait_bit(3, 1'b1);
        chk("rf_power_on", drive.rf_power_on, 1'b0);
        expect_at(5);
        expect_at(4);
        operator_panel_inst.set_front(1'b0);
        cyc(DEB + 10);
        chk("rf_power_on front ignored", drive.rf_power_on, 1'b1);
        operator_panel_inst.set_front(1'b1);
        operator_panel_inst.set_fault(4'h1);
        wait_bit(1, 1'b1);
        operator_panel_inst.set_fault(4'h0);
        operator_panel_inst.toggle_key();
        wait_bit(5, 1'b1);
        chk("fault_shutdown", drive.fault_shutdown, 1'b0);
        expect_at(4);
    endtask

    initial begin
        rst(1'b0);
        cyc(DEB + 20);
        chk("outputs idle after reset", dv === 6'h00, 1'b1);
        t_enable();
        t_key_open();
        t_interlock();
        t_front_key();
        t_over_temp();
        t_volt_faults();
        t_keyless();
        final_report();
    end
endmodule
`default_nettype wire
